// ===== host_uart_model.sv
// host side serial partner that sends and decodes characters
`timescale 1ns/1ps
module host_uart_model #(
    parameter int BIT = 64
) (
    input  wire logic  clk_i,
    input  wire logic  txd_i,
    output logic       rxd_o,
    output logic [7:0] got_o,
    output int         n_got_o
);
    // sole driver of the receive wire, idle high
    initial begin
        rxd_o = 1'b1;
        n_got_o = 0;
    end
    // start, data lsb first, optional parity, one stop
    task automatic send(input logic [7:0] b, input logic has_p, input logic p);
        logic [10:0] f;
        f = {1'b1, p, b, 1'b0};
        for (int i = 0; i < (has_p ? 11 : 10); i++) begin
            rxd_o <= (i == 9 && !has_p) ? 1'b1 : f[i];
            repeat (BIT) @(posedge clk_i);
        end
    endtask
    // holds the line low for a break
    task automatic low(input int n);
        rxd_o <= 1'b0;
        repeat (n) @(posedge clk_i);
        rxd_o <= 1'b1;
    endtask
    // decodes port characters mid-bit
    always begin
        @(negedge txd_i);
        repeat (BIT / 2) @(posedge clk_i);
        for (int i = 0; i < 8; i++) begin
            repeat (BIT) @(posedge clk_i);
            got_o[i] = txd_i;
        end
        repeat (BIT) @(posedge clk_i);
        n_got_o = n_got_o + 1;
    end
endmodule // host_uart_model

// ===== uart_baud_tick.sv
// fractional phase accumulator that yields the oversampling tick
`timescale 1ns/1ps
module uart_baud_tick
    import uart_host_port_pkg::*;
#(
    parameter int unsigned ACC_W = BAUD_ACC_W
) (
    input  wire logic             clk_i,
    input  wire logic             reset_n_i,
    input  wire logic [ACC_W-1:0] increment_i,
    output logic                  tick_o
);
    logic [ACC_W-1:0] phase;
    logic [ACC_W:0]   next_sum;

    // carry out of the accumulator marks one tick
    assign next_sum = {1'b0, phase} + {1'b0, increment_i};

    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            phase  <= '0;
            tick_o <= 1'b0;
        end else begin
            phase  <= next_sum[ACC_W-1:0];
            tick_o <= next_sum[ACC_W];
        end
    end
endmodule // uart_baud_tick

// ===== uart_host_port.sv
// host-facing serial port with flow control, break reset, break send and bypass
//
// Functional notes
// R1: flow control is on straight after reset without any register write.
// R2: with clear-to-send held low and request-to-send unused the transmitter runs freely.
// R3: characters carry 8 data bits, parity none, odd or even and one or two stop bits.
// R4: the baud generator covers low rates up to the top rate, flow control on or off.
// R5: standard rates come from a fractional divider with small error.
// R6: a continuous low on receive data is a break and its length is measured.
// R7: a break longer than the break-reset timeout requests a device reset.
// R8: a break-reset timeout of zero, the default, disables the break reset.
// R9: software can hold transmit data low to send a break that wakes the host.
// R10: all serial outputs are undriven while the device is held in reset; gpio_txd_o and gpio_rts_n_o have no enable and are driven high in reset.
// R11: other parties on the shared bus release it once this reset is deasserted.
// R12: after reset the host lines connect to this port, not to the bypass path.
// R13: a bypass command routes the lines to the general pins and enters deep sleep.
// R14: bypass holds until a physical reset; no command leaves it.
// R15: the host closes every wireless link before it commands bypass.
// R16: during reset the input pulls are down and the output pulls are up.
// R17: request-to-send drops when the receive holder is full and sending waits on clear-to-send.
`timescale 1ns/1ps
module uart_host_port
    import uart_host_port_pkg::*;
(
    input  wire logic        clk_i,
    input  wire logic        reset_n_i,
    input  wire logic [7:0]  avs_address_i,
    input  wire logic        avs_read_i,
    input  wire logic        avs_write_i,
    input  wire logic [31:0] avs_writedata_i,
    output logic      [31:0] avs_readdata_o,
    output logic             avs_waitrequest_o,
    input  wire logic        host_rxd_i,
    input  wire logic        clear_to_send_n_in_i,
    output logic             host_txd_o,
    output logic             host_txd_oe_o,
    output logic             request_to_send_n_out_o,
    output logic             request_to_send_oe_o,
    output logic             pull_en_o,
    input  wire logic        gpio_rxd_i,
    input  wire logic        gpio_cts_n_i,
    output logic             gpio_txd_o,
    output logic             gpio_rts_n_o,
    output logic             bypass_o,
    output logic             deep_sleep_o,
    output logic             device_reset_req_o,
    output logic             irq_o
);

    // parity bit for a character, shared by sender and receiver
    function automatic logic parity_of(input logic [7:0] data, input logic [1:0] mode);
        parity_of = (mode == PARITY_ODD) ? ~(^data) : (^data);
    endfunction

    ////////////////////////////////////////////////////////////////////////////////
    // bus slave
    ////////////////////////////////////////////////////////////////////////////////
    logic [4:0]      ctrl;
    logic [15:0]     baud_inc;
    logic [EV_W-1:0] status;
    logic [EV_W-1:0] mask;
    logic [23:0]     brk_timeout;
    logic [23:0]     brk_duration;
    logic [7:0]      tx_buf;
    logic            tx_pending;
    logic [7:0]      rx_hold;
    logic            rx_full;
    logic            bypass;

    wire req       = avs_read_i | avs_write_i;
    wire accept    = req & ~avs_waitrequest_o;          // edge where waitrequest low is seen
    wire wr_acc    = accept & avs_write_i;
    wire rd_acc    = accept & avs_read_i;
    wire sel_ctrl  = avs_address_i == CTRL_OFFSET;
    wire sel_baud  = avs_address_i == BAUD_OFFSET;
    wire sel_txd   = avs_address_i == TXDATA_OFFSET;
    wire sel_rxd   = avs_address_i == RXDATA_OFFSET;
    wire sel_stat  = avs_address_i == STATUS_OFFSET;
    wire sel_line  = avs_address_i == LINE_OFFSET;
    wire sel_mask  = avs_address_i == MASK_OFFSET;
    wire sel_tmo   = avs_address_i == BRK_TIMEOUT_OFFSET;
    wire sel_dur   = avs_address_i == BRK_DURATION_OFFSET;

    wire       flow_en    = ctrl[CTRL_FLOW_BIT];
    wire [1:0] par_mode   = ctrl[CTRL_PARITY_LSB +: 2];
    wire       two_stop   = ctrl[CTRL_STOP2_BIT];
    wire       send_break = ctrl[CTRL_BREAK_BIT];

    wire [31:0] line_word = {26'h0, bypass, clear_to_send_n_in_i, host_rxd_i,
                             rx_full, tx_pending, flow_en};

    // read data selection, unmapped offsets read as zero
    wire [31:0] rd_mux =
        sel_ctrl ? {27'h0, ctrl} :
        sel_baud ? {16'h0, baud_inc} :
        sel_rxd  ? {24'h0, rx_hold} :
        sel_stat ? {26'h0, status} :
        sel_line ? line_word :
        sel_mask ? {26'h0, mask} :
        sel_tmo  ? {8'h0, brk_timeout} :
        sel_dur  ? {8'h0, brk_duration} : 32'h0;

    // one wait cycle per access; read data settle while waitrequest is high
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            avs_waitrequest_o <= 1'b1;
            avs_readdata_o    <= 32'h0;
        end else begin
            avs_waitrequest_o <= ~(req & avs_waitrequest_o);
            avs_readdata_o    <= rd_mux;
        end
    end

    // writable configuration; bypass bit is write-one only and sticks
    wire enter_bypass = wr_acc & sel_ctrl & avs_writedata_i[CTRL_BYPASS_BIT];
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            ctrl        <= CTRL_RESET;                  // see R1
            baud_inc    <= BAUD_INC_RESET;              // see R5
            mask        <= '0;
            brk_timeout <= BRK_TIMEOUT_RESET;           // see R8
        end else if (wr_acc) begin
            if (sel_ctrl) ctrl <= avs_writedata_i[CTRL_BREAK_BIT:0];
            if (sel_baud) baud_inc <= avs_writedata_i[15:0];
            if (sel_mask) mask <= avs_writedata_i[EV_W-1:0];
            if (sel_tmo)  brk_timeout <= avs_writedata_i[23:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // bypass and reset-time pin state
    ////////////////////////////////////////////////////////////////////////////////
    // once set only a physical reset clears bypass
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            bypass <= 1'b0;                             // see R12
        end else if (enter_bypass) begin
            bypass <= 1'b1;                             // see R13 R14
        end
    end

    // pulls on and drivers off under reset, drivers on after release
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            pull_en_o            <= 1'b1;               // see R16
            host_txd_oe_o        <= 1'b0;               // see R10
            request_to_send_oe_o <= 1'b0;               // see R10
            bypass_o             <= 1'b0;
            deep_sleep_o         <= 1'b0;
        end else begin
            pull_en_o            <= 1'b0;
            host_txd_oe_o        <= 1'b1;
            request_to_send_oe_o <= 1'b1;
            bypass_o             <= bypass;
            deep_sleep_o         <= bypass;             // see R13
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // baud tick
    ////////////////////////////////////////////////////////////////////////////////
    logic tick;

    uart_baud_tick #(.ACC_W(BAUD_ACC_W)) u_baud (
        .clk_i       (clk_i),
        .reset_n_i   (reset_n_i),
        .increment_i (baud_inc),                        // see R4 R5
        .tick_o      (tick)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // transmitter
    ////////////////////////////////////////////////////////////////////////////////
    tx_state_type tx_state;
    tx_state_type next_tx_state;
    logic [2:0]   tx_cnt;
    logic [2:0]   tx_bit;
    logic [7:0]   tx_shift;
    logic         tx_line;
    logic         tx_second_stop;

    wire cts_ok   = ~flow_en | ~clear_to_send_n_in_i;   // see R2 R17
    wire tx_load  = wr_acc & sel_txd & ~tx_pending & ~bypass;
    wire bit_end  = tick & (tx_cnt == 3'(OVERSAMPLE - 1));
    wire tx_begin = (tx_state == TX_IDLE) & tx_pending & cts_ok & ~send_break & tick;
    wire tx_done  = (tx_state == TX_STOP) & bit_end & (~two_stop | tx_second_stop);

    // next transmit state
    always_comb begin
        next_tx_state = tx_state;
        case (tx_state)
            TX_IDLE:   if (tx_begin) next_tx_state = TX_START;
            TX_START:  if (bit_end) next_tx_state = TX_DATA;
            TX_DATA:   if (bit_end && tx_bit == 3'h7)
                           next_tx_state = (par_mode == PARITY_NONE) ? TX_STOP : TX_PARITY;
            TX_PARITY: if (bit_end) next_tx_state = TX_STOP;
            TX_STOP:   if (tx_done) next_tx_state = TX_IDLE;
            default:   next_tx_state = TX_IDLE;
        endcase
    end

    // line level for the current state; idle line low while a break is asked
    wire next_tx_line =
        (tx_state == TX_START)  ? 1'b0 :
        (tx_state == TX_DATA)   ? tx_shift[0] :
        (tx_state == TX_PARITY) ? parity_of(tx_buf, par_mode) :
        (tx_state == TX_IDLE)   ? ~send_break : 1'b1;   // see R9

    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            tx_state <= TX_IDLE;
            tx_line  <= 1'b1;
        end else begin
            tx_state <= next_tx_state;
            tx_line  <= next_tx_line;
        end
    end

    // tick and bit counters plus shift register
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            tx_cnt         <= 3'h0;
            tx_bit         <= 3'h0;
            tx_shift       <= 8'h00;
            tx_second_stop <= 1'b0;
        end else if (tx_begin) begin
            tx_cnt         <= 3'h0;
            tx_bit         <= 3'h0;
            tx_shift       <= tx_buf;                   // see R3
            tx_second_stop <= 1'b0;
        end else if (tick) begin
            tx_cnt <= tx_cnt + 3'h1;
            if (bit_end && tx_state == TX_DATA) begin
                tx_bit   <= tx_bit + 3'h1;
                tx_shift <= {1'b0, tx_shift[7:1]};
            end
            if (bit_end && tx_state == TX_STOP) tx_second_stop <= 1'b1;
        end
    end

    // single holding register in front of the shifter
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            tx_buf     <= 8'h00;
            tx_pending <= 1'b0;
        end else if (tx_load) begin
            tx_buf     <= avs_writedata_i[7:0];
            tx_pending <= 1'b1;
        end else if (tx_done) begin
            tx_pending <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // receiver
    ////////////////////////////////////////////////////////////////////////////////
    rx_state_type rx_state;
    rx_state_type next_rx_state;
    logic [2:0]   rx_cnt;
    logic [2:0]   rx_bit;
    logic [7:0]   rx_shift;
    logic         rx_second_stop;

    wire rxd       = host_rxd_i;
    wire rx_mid    = tick & (rx_cnt == 3'(OVERSAMPLE / 2 - 1));
    wire rx_end    = tick & (rx_cnt == 3'(OVERSAMPLE - 1));
    wire rx_go     = (rx_state == RX_IDLE) & ~rxd & ~bypass;
    wire rx_stop   = (rx_state == RX_STOP) & rx_end & (~two_stop | rx_second_stop | ~rxd);
    wire rx_frm    = rx_stop & ~rxd;
    wire rx_good   = rx_stop & rxd;
    wire rx_brk    = rx_frm & (rx_shift == 8'h00);     // see R6
    wire rx_par_er = (rx_state == RX_PARITY) & rx_end & (rxd != parity_of(rx_shift, par_mode));
    wire rx_pop    = rd_acc & sel_rxd;

    always_comb begin
        next_rx_state = rx_state;
        case (rx_state)
            RX_IDLE:   if (rx_go) next_rx_state = RX_START;
            RX_START:  if (rx_mid) next_rx_state = rxd ? RX_IDLE : RX_DATA;
            RX_DATA:   if (rx_end && rx_bit == 3'h7)
                           next_rx_state = (par_mode == PARITY_NONE) ? RX_STOP : RX_PARITY;
            RX_PARITY: if (rx_end) next_rx_state = RX_STOP;
            RX_STOP:   if (rx_stop) next_rx_state = RX_IDLE;
            default:   next_rx_state = RX_IDLE;
        endcase
    end

    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            rx_state <= RX_IDLE;
        end else begin
            rx_state <= next_rx_state;
        end
    end

    // counters restart at mid start bit so later samples land mid-bit
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            rx_cnt         <= 3'h0;
            rx_bit         <= 3'h0;
            rx_shift       <= 8'h00;
            rx_second_stop <= 1'b0;
        end else if (rx_go || (rx_state == RX_START && rx_mid)) begin
            rx_cnt         <= 3'h0;
            rx_bit         <= 3'h0;
            rx_second_stop <= 1'b0;
        end else if (tick) begin
            rx_cnt <= rx_cnt + 3'h1;
            if (rx_end && rx_state == RX_DATA) begin
                rx_bit   <= rx_bit + 3'h1;
                rx_shift <= {rxd, rx_shift[7:1]};
            end
            if (rx_end && rx_state == RX_STOP) rx_second_stop <= 1'b1;
        end
    end

    // holding register; a pop in the same cycle as a new byte keeps the new byte
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            rx_hold <= 8'h00;
            rx_full <= 1'b0;
        end else if (rx_good && (!rx_full || rx_pop)) begin
            rx_hold <= rx_shift;
            rx_full <= 1'b1;
        end else if (rx_pop) begin
            rx_full <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // break length and break reset
    ////////////////////////////////////////////////////////////////////////////////
    logic [7:0]       us_pre;
    logic [BRK_W-1:0] brk_us;
    logic             brk_seen;

    wire us_tick  = us_pre == 8'(US_CYCLES - 1);
    wire brk_trip = ~rxd & ~bypass & (brk_timeout != 24'h0)   // see R8
                    & (brk_us > brk_timeout);                      // see R7

    // low-time counter in microseconds, saturating
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            us_pre <= 8'h00;
            brk_us <= '0;
        end else if (rxd) begin
            us_pre <= 8'h00;
            brk_us <= '0;
        end else begin
            us_pre <= us_tick ? 8'h00 : us_pre + 8'h01;
            if (us_tick && brk_us != {BRK_W{1'b1}}) brk_us <= brk_us + 1'b1;  // see R6
        end
    end

    // duration of the last break is kept when the line returns high
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            brk_seen     <= 1'b0;
            brk_duration <= 24'h0;
        end else if (rx_brk) begin
            brk_seen <= 1'b1;
        end else if (rxd && brk_seen) begin
            brk_seen     <= 1'b0;
            brk_duration <= brk_us;                     // see R6
        end
    end

    // reset request holds until the system reset removes it
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            device_reset_req_o <= 1'b0;
        end else if (brk_trip) begin
            device_reset_req_o <= 1'b1;                 // see R7
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // status, interrupt and pin outputs
    ////////////////////////////////////////////////////////////////////////////////
    wire [EV_W-1:0] events = {rx_good & rx_full & ~rx_pop, rx_frm, rx_par_er,
                              rx_brk, tx_done, rx_good};
    wire            st_clr = rd_acc & sel_stat;
    wire [EV_W-1:0] next_status = (st_clr ? {EV_W{1'b0}} : status) | events;  // set wins

    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            status <= '0;
            irq_o  <= 1'b0;
        end else begin
            status <= next_status;
            irq_o  <= |(next_status & mask);
        end
    end

    // normal path or straight-through bypass to the general pins
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            host_txd_o              <= 1'b1;
            request_to_send_n_out_o <= 1'b1;
            gpio_txd_o              <= 1'b1;
            gpio_rts_n_o            <= 1'b1;
        end else if (bypass) begin
            host_txd_o              <= gpio_rxd_i;      // see R13
            request_to_send_n_out_o <= gpio_cts_n_i;
            gpio_txd_o              <= host_rxd_i;
            gpio_rts_n_o            <= clear_to_send_n_in_i;
        end else begin
            host_txd_o              <= tx_line;
            request_to_send_n_out_o <= flow_en & rx_full;  // see R17
            gpio_txd_o              <= 1'b1;
            gpio_rts_n_o            <= 1'b1;
        end
    end

endmodule // uart_host_port

// ===== uart_host_port_assertions.sv
// pin-level checks of the host serial port
`timescale 1ns/1ps
module uart_host_port_assertions (
    input wire logic clk_i,
    input wire logic reset_n_i,
    input wire logic avs_read_i,
    input wire logic avs_write_i,
    input wire logic avs_waitrequest_o,
    input wire logic host_rxd_i,
    input wire logic clear_to_send_n_in_i,
    input wire logic host_txd_oe_o,
    input wire logic request_to_send_oe_o,
    input wire logic pull_en_o,
    input wire logic gpio_txd_o,
    input wire logic gpio_rts_n_o,
    input wire logic bypass_o,
    input wire logic deep_sleep_o,
    input wire logic device_reset_req_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (!reset_n_i);
    // request seen while waiting, then exactly one answer cycle
    sequence s_req;
        (avs_read_i || avs_write_i) && avs_waitrequest_o;
    endsequence
    sequence s_ans;
        !avs_waitrequest_o ##1 avs_waitrequest_o;
    endsequence
    a_one_wait: assert property (s_req |=> s_ans)
        else $error("wait not one cycle");
    a_tristate_reset: assert property ($rose(reset_n_i) |->
        $past(!host_txd_oe_o && !request_to_send_oe_o && pull_en_o))
        else $error("driven in reset");
    a_driven_after: assert property ($past(reset_n_i) |->
        host_txd_oe_o && request_to_send_oe_o && !pull_en_o)
        else $error("idle after reset");
    a_bypass_holds: assert property (bypass_o |=> bypass_o)
        else $error("bypass left");
    a_sleep_bypass: assert property (deep_sleep_o == bypass_o)
        else $error("sleep mismatch");
    a_gpio_copy: assert property (bypass_o && $past(bypass_o) |->
        gpio_txd_o == $past(host_rxd_i) && gpio_rts_n_o == $past(clear_to_send_n_in_i))
        else $error("bypass copy wrong");
    a_host_routing: assert property (!bypass_o |-> gpio_txd_o && gpio_rts_n_o)
        else $error("bypass pins active");
    a_reset_req_holds: assert property (device_reset_req_o |=> device_reset_req_o)
        else $error("reset req dropped");
endmodule // uart_host_port_assertions
bind uart_host_port uart_host_port_assertions chk_u (.*);

// ===== uart_host_port_pkg.sv
// constants shared by the host serial port and its baud tick generator
package uart_host_port_pkg;

    // clock and time base
    localparam int unsigned CLK_HZ         = 20_000_000;
    localparam int unsigned TIME_BASE_US   = 1;            // break timing unit, microseconds
    localparam int unsigned US_CYCLES      = (CLK_HZ / 1_000_000) * TIME_BASE_US;
    localparam int unsigned OVERSAMPLE     = 8;            // baud ticks per bit
    localparam int unsigned BAUD_ACC_W     = 16;
    localparam int unsigned DEFAULT_BAUD   = 115200;
    localparam logic [15:0] BAUD_INC_RESET =
        16'((64'(DEFAULT_BAUD) * OVERSAMPLE * 65536 + CLK_HZ / 2) / CLK_HZ);

    // register byte offsets
    localparam logic [7:0] CTRL_OFFSET       = 8'h00;
    localparam logic [7:0] BAUD_OFFSET       = 8'h04;
    localparam logic [7:0] TXDATA_OFFSET     = 8'h08;
    localparam logic [7:0] RXDATA_OFFSET     = 8'h0C;
    localparam logic [7:0] STATUS_OFFSET     = 8'h10;
    localparam logic [7:0] LINE_OFFSET       = 8'h14;
    localparam logic [7:0] MASK_OFFSET       = 8'h18;
    localparam logic [7:0] BRK_TIMEOUT_OFFSET = 8'h1C;
    localparam logic [7:0] BRK_DURATION_OFFSET = 8'h20;

    // control field positions
    localparam int unsigned CTRL_FLOW_BIT     = 0;
    localparam int unsigned CTRL_PARITY_LSB   = 1;        // two bits
    localparam int unsigned CTRL_STOP2_BIT    = 3;
    localparam int unsigned CTRL_BREAK_BIT    = 4;
    localparam int unsigned CTRL_BYPASS_BIT   = 5;
    localparam logic [4:0]  CTRL_RESET        = 5'h01;    // flow control on, 8N1

    // parity modes
    localparam logic [1:0] PARITY_NONE = 2'h0;
    localparam logic [1:0] PARITY_ODD  = 2'h1;
    localparam logic [1:0] PARITY_EVEN = 2'h2;

    // status event bits
    localparam int unsigned EV_RX_READY = 0;
    localparam int unsigned EV_TX_DONE  = 1;
    localparam int unsigned EV_BREAK    = 2;
    localparam int unsigned EV_PARITY   = 3;
    localparam int unsigned EV_FRAMING  = 4;
    localparam int unsigned EV_OVERRUN  = 5;
    localparam int unsigned EV_W        = 6;

    localparam int unsigned BRK_W            = 24;
    localparam logic [23:0] BRK_TIMEOUT_RESET = 24'h000000;

    typedef enum logic [2:0] {TX_IDLE, TX_START, TX_DATA, TX_PARITY, TX_STOP} tx_state_type;
    typedef enum logic [2:0] {RX_IDLE, RX_START, RX_DATA, RX_PARITY, RX_STOP} rx_state_type;

endpackage

// ===== uart_host_port_tb.sv
// self-checking bench of the host serial port
`timescale 1ns/1ps
module uart_host_port_tb;
    import uart_host_port_pkg::*;
    localparam int BIT = 64;
    logic clk_i = 1'b0, reset_n_i = 1'b0, avs_read_i = 1'b0, avs_write_i = 1'b0;
    logic clear_to_send_n_in_i = 1'b1, host_rxd_i, avs_waitrequest_o, host_txd_o;
    logic host_txd_oe_o, request_to_send_n_out_o, request_to_send_oe_o, pull_en_o;
    logic gpio_txd_o, gpio_rts_n_o, bypass_o, deep_sleep_o, device_reset_req_o, irq_o;
    logic [7:0] avs_address_i = 8'h00, got, b;
    logic [31:0] avs_writedata_i = 32'h0, avs_readdata_o, rdat;
    int n_fail = 0, n_compared = 0, cyc = 0, n_got;
    uart_host_port dut_u (.*, .gpio_rxd_i(clear_to_send_n_in_i), .gpio_cts_n_i(1'b1));
    host_uart_model #(.BIT(BIT)) host_u (.clk_i, .txd_i(host_txd_o), .rxd_o(host_rxd_i),
        .got_o(got), .n_got_o(n_got));
    // clock and run ceiling
    always #25 clk_i = ~clk_i;
    always @(posedge clk_i) begin
        cyc <= cyc + 1;
        if (cyc == 40000) begin
            n_fail++;
            conclude();
        end
    end
    task automatic conclude();
        $display("compared %0d failed %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        n_compared++;
        if (g !== e) begin
            n_fail++;
            $display("BAD %0t got %h exp %h", $time, g, e);
        end
    endtask
    // bus cycles held until waitrequest is seen low
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_i);
        avs_address_i <= a;
        avs_writedata_i <= d;
        avs_write_i <= 1'b1;
        do @(posedge clk_i); while (avs_waitrequest_o !== 1'b0);
        avs_write_i <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a);
        @(posedge clk_i);
        avs_address_i <= a;
        avs_read_i <= 1'b1;
        do @(posedge clk_i); while (avs_waitrequest_o !== 1'b0);
        rdat = avs_readdata_o;
        avs_read_i <= 1'b0;
    endtask
    task automatic do_reset();
        @(posedge clk_i);
        reset_n_i <= 1'b0;
        repeat (3) @(posedge clk_i);
        reset_n_i <= 1'b1;
        repeat (2) @(posedge clk_i);
    endtask
    // defaults, flow-held transmit, irq
    task automatic t_tx();
        chk({host_txd_oe_o, request_to_send_oe_o, pull_en_o, bypass_o}, 4'hC);
        rd(CTRL_OFFSET);
        chk(rdat, 32'h1);
        rd(BRK_TIMEOUT_OFFSET);
        chk(rdat, 32'h0);
        rd(8'h3C);
        chk(rdat, 32'h0);
        wr(BAUD_OFFSET, 32'h2000);
        wr(MASK_OFFSET, 32'h2);
        wr(TXDATA_OFFSET, 32'hA5);
        repeat (12 * BIT) @(posedge clk_i);
        chk(n_got, 0);
        clear_to_send_n_in_i <= 1'b0;
        repeat (12 * BIT) @(posedge clk_i);
        chk({n_got[7:0], got, 7'h0, irq_o}, 32'h0001A501);
        rd(STATUS_OFFSET);
        @(posedge clk_i);
        chk({rdat, irq_o}, 33'h4);
    endtask
    // receive in each parity mode
    task automatic t_rx();
        for (int m = 0; m < 3; m++) begin
            b = 8'h3C + 8'(m);
            wr(CTRL_OFFSET, 32'(1 + 2 * m));
            host_u.send(b, m != 0, (^b) ^ (m == 1));
            repeat (4) @(posedge clk_i);
            chk({request_to_send_n_out_o, irq_o}, 2'h2);
            rd(STATUS_OFFSET);
            chk(rdat, 32'h1);
            rd(RXDATA_OFFSET);
            chk(rdat, 32'(b));
        end
    endtask
    // break out, break in, break reset
    task automatic t_break();
        wr(CTRL_OFFSET, 32'h11);
        repeat (4 * BIT) @(posedge clk_i);
        chk(host_txd_o, 1'b0);
        wr(CTRL_OFFSET, 32'h01);
        repeat (2 * BIT) @(posedge clk_i);
        chk(host_txd_o, 1'b1);
        host_u.low(40 * US_CYCLES);
        chk(device_reset_req_o, 1'b0);
        rd(STATUS_OFFSET);
        chk(rdat[EV_BREAK], 1'b1);
        rd(BRK_DURATION_OFFSET);
        chk(rdat, 32'h28);
        wr(BRK_TIMEOUT_OFFSET, 32'hA);
        host_u.low(15 * US_CYCLES);
        repeat (2) @(posedge clk_i);
        chk(device_reset_req_o, 1'b1);
        do_reset();
    endtask
    // bypass copy, hold and exit
    task automatic t_bypass();
        wr(CTRL_OFFSET, 32'h21);
        repeat (2) @(posedge clk_i);
        chk(bypass_o & deep_sleep_o, 1'b1);
        host_u.low(8);
        chk({gpio_txd_o, host_txd_o}, 2'h0);
        wr(CTRL_OFFSET, 32'h01);
        chk(bypass_o, 1'b1);
        do_reset();
        chk(bypass_o, 1'b0);
    endtask
    initial begin
        do_reset();
        t_tx();
        t_rx();
        t_break();
        t_bypass();
        conclude();
    end
endmodule // uart_host_port_tb
